//--- core/rbmc_top.sv
// Register bus magnitude comparator: shift register, bus comparator and APB control
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rbmc_map.svh"

module rbmc_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RBMC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic clock_pulse,
   input wire logic [`RBMC_WORD_W-1:0] data_bus_in,
   output logic [`RBMC_WORD_W-1:0] data_bus_out,
   output logic data_bus_oe,
   input wire logic prio_serial_in,
   output logic prio_serial_out,
   output logic reg_above_bus_flag_out,
   output logic reg_above_bus_flag_oe,
   output logic reg_below_bus_flag_out,
   output logic reg_below_bus_flag_oe,
   output logic reg_matches_bus_flag_out,
   output logic reg_matches_bus_flag_oe
);

   //--------------------------------------------------------------
   // Declarations
   //--------------------------------------------------------------
   logic [`RBMC_CTRL_W-1:0] ctrl_ff;
   logic [`RBMC_WORD_W-1:0] word_ff;
   logic [`RBMC_WORD_W-1:0] bus_s1_ff;
   logic [`RBMC_WORD_W-1:0] bus_s2_ff;
   logic prio_s1_ff;
   logic prio_s2_ff;
   logic cp_s1_ff;
   logic cp_s2_ff;
   logic cp_s3_ff;
   logic cp_rise;
   rbmc_pkg::rbmc_mode_t mode;
   logic status_gate_n;
   logic num_format;
   logic reg_above;
   logic reg_below;
   logic reg_equal;
   logic above_oe_ff;
   logic below_oe_ff;
   logic equal_oe_ff;
   logic prio_out_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic apb_setup;
   logic apb_access;
   logic addr_hit;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   //--------------------------------------------------------------
   // Pin synchronisers
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus_s1_ff <= `RBMC_WORD_RST;
         bus_s2_ff <= `RBMC_WORD_RST;
         prio_s1_ff <= 1'b0;
         prio_s2_ff <= 1'b0;
         cp_s1_ff <= 1'b0;
         cp_s2_ff <= 1'b0;
         cp_s3_ff <= 1'b0;
      end
      else
      begin
         bus_s1_ff <= data_bus_in;
         bus_s2_ff <= bus_s1_ff;
         prio_s1_ff <= prio_serial_in;
         prio_s2_ff <= prio_s1_ff;
         cp_s1_ff <= clock_pulse;
         cp_s2_ff <= cp_s1_ff;
         cp_s3_ff <= cp_s2_ff;
      end
   end

   assign cp_rise = cp_s2_ff & ~cp_s3_ff;

   //--------------------------------------------------------------
   // APB slave
   //--------------------------------------------------------------
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable;
   assign addr_hit = (paddr == `RBMC_CTRL_ADDR) || (paddr == `RBMC_STAT_ADDR);
   assign pready = 1'b1;
   assign pslverr = apb_access & ~addr_hit;
   assign prdata = prdata_ff;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_ff <= `RBMC_CTRL_RST;
      end
      else if (apb_access && pwrite && (paddr == `RBMC_CTRL_ADDR))
      begin
         ctrl_ff <= pwdata[`RBMC_CTRL_W-1:0];
      end
   end

   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      if (paddr == `RBMC_CTRL_ADDR)
      begin
         nxt_prdata[`RBMC_CTRL_W-1:0] = ctrl_ff;
      end
      else if (paddr == `RBMC_STAT_ADDR)
      begin
         nxt_prdata[`RBMC_STAT_WORD_LSB +: `RBMC_WORD_W] = word_ff;
         nxt_prdata[`RBMC_STAT_EQ] = reg_equal;
         nxt_prdata[`RBMC_STAT_GT] = reg_above;
         nxt_prdata[`RBMC_STAT_LT] = reg_below;
         nxt_prdata[`RBMC_STAT_PRIO] = prio_out_ff;
      end
   end

   // Read data is captured in the setup cycle so it stands in the access cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prdata_ff <= 32'h0000_0000;
      end
      else if (apb_setup && !pwrite)
      begin
         prdata_ff <= nxt_prdata;
      end
   end

   //--------------------------------------------------------------
   // Mode decode
   //--------------------------------------------------------------
   // both high is load
   assign mode = rbmc_pkg::rbmc_mode_t'({ctrl_ff[`RBMC_CTRL_SEL_LO], ctrl_ff[`RBMC_CTRL_SEL_HI]});
   assign status_gate_n = ctrl_ff[`RBMC_CTRL_GATE_N];
   assign num_format = ctrl_ff[`RBMC_CTRL_FMT];

   //--------------------------------------------------------------
   // Shift register
   //--------------------------------------------------------------
   // eight-bit shift register
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         word_ff <= `RBMC_WORD_RST;
      end
      else if (cp_rise)
      begin
         case (mode)
            rbmc_pkg::RBMC_HOLD: word_ff <= word_ff;
            rbmc_pkg::RBMC_READ: word_ff <= word_ff;
            rbmc_pkg::RBMC_SHIFT: word_ff <= {word_ff[`RBMC_WORD_W-2:0], prio_s2_ff};
            rbmc_pkg::RBMC_LOAD: word_ff <= bus_s2_ff;
            default: word_ff <= word_ff;
         endcase
      end
   end

   //--------------------------------------------------------------
   // Bus drivers
   //--------------------------------------------------------------
   // drive word out
   assign data_bus_out = word_ff;
   assign data_bus_oe = (mode == rbmc_pkg::RBMC_READ);

   //--------------------------------------------------------------
   // Comparator
   //--------------------------------------------------------------
   // unsigned or signed compare
   always_comb
   begin
      reg_equal = (word_ff == bus_s2_ff);
      if (num_format)
      begin
         reg_above = $signed(word_ff) > $signed(bus_s2_ff);
         reg_below = $signed(word_ff) < $signed(bus_s2_ff);
      end
      else
      begin
         reg_above = word_ff > bus_s2_ff;
         reg_below = word_ff < bus_s2_ff;
      end
   end

   //--------------------------------------------------------------
   // Status outputs
   //--------------------------------------------------------------
   // Enable high means the pin is pulled low; released means enable low
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         above_oe_ff <= 1'b0;
         below_oe_ff <= 1'b0;
         equal_oe_ff <= 1'b0;
      end
      else if (status_gate_n)
      begin
         above_oe_ff <= 1'b0;
         below_oe_ff <= 1'b0;
         equal_oe_ff <= 1'b0;
      end
      else
      begin
         equal_oe_ff <= ~reg_equal;
         above_oe_ff <= prio_s2_ff & ~reg_above;
         below_oe_ff <= prio_s2_ff & ~reg_below;
      end
   end

   assign reg_above_bus_flag_out = 1'b0;
   assign reg_below_bus_flag_out = 1'b0;
   assign reg_matches_bus_flag_out = 1'b0;
   assign reg_above_bus_flag_oe = above_oe_ff;
   assign reg_below_bus_flag_oe = below_oe_ff;
   assign reg_matches_bus_flag_oe = equal_oe_ff;

   //--------------------------------------------------------------
   // Priority and serial output
   //--------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prio_out_ff <= 1'b0;
      end
      else if (mode == rbmc_pkg::RBMC_SHIFT)
      begin
         prio_out_ff <= word_ff[`RBMC_WORD_W-1];
      end
      else
      begin
         prio_out_ff <= reg_equal;
      end
   end

   assign prio_serial_out = prio_out_ff;

   //--------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------
   property p_hold_stable;
      cp_rise && mode == rbmc_pkg::RBMC_HOLD |=> $stable(word_ff);
   endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("word changed in hold");

   property p_edge_only;
      !cp_rise |=> $stable(word_ff);
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("word changed without edge");

   property p_shift_step;
      cp_rise && mode == rbmc_pkg::RBMC_SHIFT
         |=> word_ff == {$past(word_ff[`RBMC_WORD_W-2:0]), $past(prio_s2_ff)};
   endproperty
   a_shift_step: assert property (p_shift_step) else $error("shift result wrong");

   property p_load_bus;
      cp_rise && mode == rbmc_pkg::RBMC_LOAD |=> word_ff == $past(bus_s2_ff);
   endproperty
   a_load_bus: assert property (p_load_bus) else $error("load did not capture bus");

   property p_oe_read;
      data_bus_oe == (!ctrl_ff[`RBMC_CTRL_SEL_LO] && ctrl_ff[`RBMC_CTRL_SEL_HI]);
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("bus enable outside read");

   property p_gate_off;
      status_gate_n ##1 status_gate_n
         |-> !above_oe_ff && !below_oe_ff && !equal_oe_ff;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("status not released by gate");

   property p_prio_low;
      !prio_s2_ff |=> !above_oe_ff && !below_oe_ff;
   endproperty
   a_prio_low: assert property (p_prio_low) else $error("greater or less driven");

   property p_prio_eq;
      rst_b && mode != rbmc_pkg::RBMC_SHIFT |=> prio_out_ff == $past(reg_equal);
   endproperty
   a_prio_eq: assert property (p_prio_eq) else $error("priority output wrong");

   property p_serial_out;
      mode == rbmc_pkg::RBMC_SHIFT |=> prio_out_ff == $past(word_ff[`RBMC_WORD_W-1]);
   endproperty
   a_serial_out: assert property (p_serial_out) else $error("serial out wrong");

   property p_above;
      !status_gate_n && prio_s2_ff && !num_format && word_ff > bus_s2_ff
         |=> equal_oe_ff && below_oe_ff && !above_oe_ff;
   endproperty
   a_above: assert property (p_above) else $error("above pattern wrong");

   property p_below;
      !status_gate_n && prio_s2_ff && !num_format && word_ff < bus_s2_ff
         |=> equal_oe_ff && above_oe_ff && !below_oe_ff;
   endproperty
   a_below: assert property (p_below) else $error("below pattern wrong");

   property p_signed;
      !status_gate_n && prio_s2_ff && num_format && word_ff == 8'h5A && bus_s2_ff == 8'hA5
         |=> !above_oe_ff && below_oe_ff;
   endproperty
   a_signed: assert property (p_signed) else $error("signed compare wrong");

   property p_equal;
      !status_gate_n |=> equal_oe_ff == !$past(word_ff == bus_s2_ff);
   endproperty
   a_equal: assert property (p_equal) else $error("equal flag wrong");

   c_load: cover property (cp_rise && mode == rbmc_pkg::RBMC_LOAD);
   c_shift: cover property (cp_rise && mode == rbmc_pkg::RBMC_SHIFT);
   c_read: cover property (data_bus_oe ##1 data_bus_oe);
   c_signed_gt: cover property (!status_gate_n && num_format && prio_s2_ff && reg_above);

endmodule : rbmc_top

`default_nettype wire

//--- core/rbmc_map.svh
// Register offsets, field positions and reset values of the comparator block
`ifndef RBMC_MAP_SVH
`define RBMC_MAP_SVH

`define RBMC_ADDR_W 12
`define RBMC_CTRL_ADDR 12'h000
`define RBMC_STAT_ADDR 12'h004

`define RBMC_CTRL_W 4
`define RBMC_CTRL_RST 4'h4
`define RBMC_CTRL_SEL_LO 0
`define RBMC_CTRL_SEL_HI 1
`define RBMC_CTRL_GATE_N 2
`define RBMC_CTRL_FMT 3

`define RBMC_STAT_WORD_LSB 0
`define RBMC_STAT_EQ 8
`define RBMC_STAT_GT 9
`define RBMC_STAT_LT 10
`define RBMC_STAT_PRIO 11

`define RBMC_WORD_W 8
`define RBMC_WORD_RST 8'h00

`endif

//--- core/rbmc_pkg.sv
// Types shared by the comparator block
package rbmc_pkg;

   // Operating modes, coded {op_select_lo, op_select_hi}, Gray along the usual path
   typedef enum logic [1:0] {
      RBMC_HOLD  = 2'b00,
      RBMC_READ  = 2'b01,
      RBMC_LOAD  = 2'b11,
      RBMC_SHIFT = 2'b10
   } rbmc_mode_t;

endpackage : rbmc_pkg

//--- testbench/rbmc_far_end.sv
// Far side model: system data bus and pulled-up status wires
`timescale 1ns/1ps
`default_nettype none
`include "rbmc_map.svh"

module rbmc_far_end (
   input wire logic clk,
   input wire logic [`RBMC_WORD_W-1:0] data_bus_out,
   input wire logic data_bus_oe,
   input wire logic bus_drive_en,
   input wire logic [`RBMC_WORD_W-1:0] bus_drive_val,
   output logic [`RBMC_WORD_W-1:0] data_bus_in,
   input wire logic [2:0] flag_out,
   input wire logic [2:0] flag_oe,
   output logic [2:0] flag_wire
);
   logic [`RBMC_WORD_W-1:0] last_ff;

   always_ff @(posedge clk)
   begin
      last_ff <= data_bus_in;
   end

   // bus resolution
   // Undriven bus shows the inverse of its last level
   always_comb
   begin
      if (data_bus_oe)
         data_bus_in = data_bus_out;
      else if (bus_drive_en)
         data_bus_in = bus_drive_val;
      else
         data_bus_in = ~last_ff;
   end

   assign flag_wire = (flag_out | ~flag_oe);
endmodule : rbmc_far_end
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking testbench of the comparator block
`timescale 1ns/1ps
`default_nettype none
`include "rbmc_map.svh"

module tb_top;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [`RBMC_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic clock_pulse, prio_serial_in, prio_serial_out, data_bus_oe, bus_drive_en;
   logic [7:0] data_bus_in, data_bus_out, bus_drive_val, w, b;
   logic [7:0] tbl [4] = '{8'h5A, 8'h10, 8'hA5, 8'h7F};
   logic [7:0] pat = 8'hC3;
   logic [2:0] f_out, f_oe, f_wire;
   int num_errors, checks_done;

   rbmc_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .clock_pulse(clock_pulse),
      .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
      .prio_serial_in(prio_serial_in), .prio_serial_out(prio_serial_out),
      .reg_matches_bus_flag_out(f_out[2]), .reg_matches_bus_flag_oe(f_oe[2]),
      .reg_above_bus_flag_out(f_out[1]), .reg_above_bus_flag_oe(f_oe[1]),
      .reg_below_bus_flag_out(f_out[0]), .reg_below_bus_flag_oe(f_oe[0]));

   rbmc_far_end u_far (.clk(clk), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
      .bus_drive_en(bus_drive_en), .bus_drive_val(bus_drive_val),
      .data_bus_in(data_bus_in), .flag_out(f_out), .flag_oe(f_oe), .flag_wire(f_wire));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task pulse;
      repeat (3) @(posedge clk);
      clock_pulse <= 1'b1;
      repeat (4) @(posedge clk);
      clock_pulse <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse

   task cmp(input logic g, input logic m, input logic p);
      logic gt, lt, eq;
      eq = (w === b);
      gt = m ? ($signed(w) > $signed(b)) : (w > b);
      lt = !gt && !eq;
      chk({29'h0, f_wire}, g ? 32'h7 : {29'h0, eq, gt | !p, lt | !p});
      chk({31'h0, prio_serial_out}, {31'h0, eq});
   endtask : cmp

   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim;
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      clock_pulse = 1'b0;
      bus_drive_en = 1'b1;
      bus_drive_val = 8'h00;
      prio_serial_in = 1'b1;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, `RBMC_CTRL_ADDR, 32'h0);
      chk(rd, 32'h4);
      chk({29'h0, f_wire}, 32'h7);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `RBMC_CTRL_ADDR, 32'h3);
      bus_drive_val <= 8'h5A;
      pulse;
      apb(1'b0, `RBMC_STAT_ADDR, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h5A);
      bus_drive_val <= 8'h99;
      repeat (10) @(posedge clk);
      apb(1'b0, `RBMC_STAT_ADDR, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h5A);
      apb(1'b1, `RBMC_CTRL_ADDR, 32'h0);
      pulse;
      apb(1'b0, `RBMC_STAT_ADDR, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h5A);
      chk({31'h0, data_bus_oe}, 32'h0);
      bus_drive_en <= 1'b0;
      apb(1'b1, `RBMC_CTRL_ADDR, 32'h2);
      repeat (6) @(posedge clk);
      chk({23'h0, data_bus_oe, data_bus_out}, 32'h15A);
      chk({31'h0, f_wire[2]}, 32'h1);
      pulse;
      apb(1'b0, `RBMC_STAT_ADDR, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h5A);
      w = 8'h5A;
      for (int g = 0; g < 2; g++)
         for (int m = 0; m < 2; m++)
         begin
            apb(1'b1, `RBMC_CTRL_ADDR, {28'h0, m[0], g[0], 2'b00});
            bus_drive_en <= 1'b1;
            for (int p = 0; p < 2; p++)
               for (int k = 0; k < 4; k++)
               begin
                  b = tbl[k];
                  bus_drive_val <= b;
                  prio_serial_in <= p[0];
                  repeat (6) @(posedge clk);
                  cmp(g[0], m[0], p[0]);
               end
         end
      apb(1'b1, `RBMC_CTRL_ADDR, 32'h1);
      repeat (6) @(posedge clk);
      for (int i = 7; i >= 0; i--)
      begin
         chk({31'h0, prio_serial_out}, {31'h0, w[7]});
         prio_serial_in <= pat[i];
         pulse;
         w = {w[6:0], pat[i]};
      end
      apb(1'b0, `RBMC_STAT_ADDR, 32'h0);
      chk({24'h0, rd[7:0]}, 32'hC3);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      chk({27'h0, prio_serial_out, data_bus_oe, f_wire}, 32'h7);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, `RBMC_CTRL_ADDR, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, `RBMC_STAT_ADDR, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h0);
      end_sim;
   end
endmodule : tb_top
`default_nettype wire
